// ---- hw/prlt_regs.sv ----
// PHY reset, multi-purpose LED and compliance test registers on AXI4-Lite
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ns
//
// Function
// (R01) Writing one to the soft reset bit resets everything as a hardware reset does and the bit reads back zero.
// (R02) Writing one to the restart bit resets the transceiver circuitry but keeps every register value.
// (R03) Reserved bits of the three registers ignore writes and read zero.
// (R04) With the collision route bit set the collision pin carries the LED output instead of collision.
// (R05) The LED polarity bit starts from the strap level, high meaning active low, and software may change it.
// (R06) The four-bit source field picks link, activity, collision, speed, duplex, blink or stretch for the LED.
// (R07) The LED reaches the alternative pin only when both its route bit and the routing enable are set.
// (R08) The routing enable bit activates routing, and while clear that path routes nothing; the collision route bit routes to the collision pin without it.
// (R09) The LED source defaults to link, or to link with activity when the function strap is set.
// (R10) Test bit 4 picks 10Base-T patterns when one and 100Base-TX patterns when zero.
// (R11) In 10Base-T test mode the low four bits pick one of fourteen patterns.
// (R12) In 100Base-TX test mode a one is sent followed by N zeros, N from bit 5 over bits 3 to 0.
// (R13) A zero 100Base-TX selection ends test pattern transmission.
// (R14) Software writes zero to the 100Base-TX selection before any new non-zero value.
// (R15) Software forces the link speed before running any compliance test.
// (R16) Without routing both pins keep their normal function and the LED drives only routed pins.
module prlt_regs
   import prlt_pkg::*;
#(
   parameter int STRETCH_CYCLES = PRLT_STRETCH_CYCLES
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [PRLT_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [PRLT_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic link_ok,
   input wire logic rx_activity,
   input wire logic tx_activity,
   input wire logic collision_in,
   input wire logic speed_100,
   input wire logic full_duplex,
   input wire logic alt_pin_func_in,
   input wire logic col_pin_strap,
   input wire logic led_function_strap,
   output logic col_pin_out,
   output logic alt_pin_out,
   output logic phy_reset_pulse,
   output logic restart_pulse,
   output logic test_tx_bit,
   output logic test_active,
   output logic test_mode_10t
);

   typedef struct packed
   {
      logic awready;
      logic wready;
      logic aw_have;
      logic w_have;
      logic [PRLT_ADDR_W-1:0] awaddr;
      logic [15:0] wdata;
      logic [1:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic col_route;
      logic pol;
      logic [3:0] led_src;
      logic alt_route;
      logic route_en;
      logic [5:0] test_cfg;
      logic strap_pending;
      logic phy_reset;
      logic restart;
      logic [PRLT_STRETCH_W-1:0] stretch;
      logic col_pin;
      logic alt_pin;
   } prlt_state_t;

   // Strap capture is armed by reset and done on the first clocked cycle
   localparam prlt_state_t REG_RST = '{strap_pending: 1'b1, default: '0};
   localparam logic [PRLT_STRETCH_W-1:0] STRETCH_LOAD =
      PRLT_STRETCH_W'(STRETCH_CYCLES - 1);

   prlt_state_t q;
   prlt_state_t s;
   logic [15:0] wword;
   logic [15:0] rword;
   logic rd_ok;
   logic wr_ok;
   logic activity;
   logic stretched;
   logic led_level;
   logic led_drive;
   logic gen_bit;
   logic gen_active;
   logic gen_10t;

   // Byte lanes 0 and 1 carry the 16-bit register; other lanes are dropped
   function automatic logic [15:0] merge(input logic [15:0] old,
      input logic [15:0] data, input logic [1:0] strb);
      logic [15:0] res;
      res = old;
      if (strb[0])
         res[7:0] = data[7:0];
      if (strb[1])
         res[15:8] = data[15:8];
      return res;
   endfunction

   function automatic logic [15:0] led_word(input prlt_state_t r);
      logic [15:0] w;
      w = '0; // see (R03)
      w[PRLT_COL_ROUTE_BIT] = r.col_route;
      w[PRLT_POL_BIT] = r.pol;
      w[PRLT_SRC_LSB +: 4] = r.led_src;
      w[PRLT_ALT_ROUTE_BIT] = r.alt_route;
      w[PRLT_ROUTE_EN_BIT] = r.route_en;
      return w;
   endfunction

   function automatic logic [15:0] test_word(input prlt_state_t r);
      logic [15:0] w;
      w = '0; // see (R03)
      w[PRLT_TEST_MSB_BIT:0] = r.test_cfg;
      return w;
   endfunction

   // Read decode; self-clearing reset bits always read zero
   always_comb
   begin
      rword = '0;
      rd_ok = 1'b1;
      unique case (s_axi_araddr)
         PRLT_ADDR_RESET:
            rword = '0; // see (R01) (R02) (R03)
         PRLT_ADDR_LED:
            rword = led_word(q);
         PRLT_ADDR_TEST:
            rword = test_word(q);
         default:
            rd_ok = 1'b0;
      endcase
   end

   assign activity = rx_activity | tx_activity;
   assign stretched = activity | (q.stretch != '0);

   always_comb
   begin
      led_level = 1'b0;
      unique case (q.led_src) // see (R06)
         PRLT_SRC_LINK:
            led_level = link_ok;
         PRLT_SRC_ACT:
            led_level = activity;
         PRLT_SRC_TX_ACT:
            led_level = tx_activity;
         PRLT_SRC_RX_ACT:
            led_level = rx_activity;
         PRLT_SRC_COL:
            led_level = collision_in;
         PRLT_SRC_SPEED_100:
            led_level = speed_100;
         PRLT_SRC_SPEED_10:
            led_level = ~speed_100;
         PRLT_SRC_FULL_DUPLEX:
            led_level = full_duplex;
         // Lit on link, dark while activity or its stretch timer is running
         PRLT_SRC_LINK_BLINK:
            led_level = link_ok & ~stretched;
         PRLT_SRC_STRETCH:
            led_level = stretched;
         PRLT_SRC_LINK_100FD:
            led_level = link_ok & speed_100 & full_duplex;
         default:
            led_level = 1'b0;
      endcase
   end

   // Polarity one means active low
   assign led_drive = led_level ^ q.pol; // see (R05)

   always_comb
   begin
      s = q;
      wword = '0;
      wr_ok = 1'b1;
      s.phy_reset = 1'b0;
      s.restart = 1'b0;

      // Power-up strap capture, repeated after a soft reset
      if (q.strap_pending)
      begin
         s.strap_pending = 1'b0;
         s.pol = col_pin_strap; // see (R05)
         s.led_src = led_function_strap ? PRLT_SRC_LINK_BLINK
            : PRLT_SRC_LINK; // see (R09)
      end

      if (q.bvalid && s_axi_bready)
         s.bvalid = 1'b0;
      if (q.awready && s_axi_awvalid)
      begin
         s.aw_have = 1'b1;
         s.awaddr = s_axi_awaddr;
      end
      if (q.wready && s_axi_wvalid)
      begin
         s.w_have = 1'b1;
         s.wdata = s_axi_wdata[15:0];
         s.wstrb = s_axi_wstrb[1:0];
      end

      if (s.aw_have && s.w_have && !s.bvalid)
      begin
         s.aw_have = 1'b0;
         s.w_have = 1'b0;
         s.bvalid = 1'b1;
         unique case (s.awaddr)
            PRLT_ADDR_RESET:
            begin
               wword = merge('0, s.wdata, s.wstrb);
               if (wword[PRLT_SOFT_RESET_BIT])
               begin
                  // Bus handshake survives so the response is not lost
                  s.col_route = REG_RST.col_route; // see (R01)
                  s.alt_route = REG_RST.alt_route;
                  s.route_en = REG_RST.route_en;
                  s.test_cfg = REG_RST.test_cfg;
                  s.stretch = REG_RST.stretch;
                  s.strap_pending = 1'b1;
                  s.phy_reset = 1'b1;
               end
               else if (wword[PRLT_RESTART_BIT])
                  s.restart = 1'b1; // see (R02)
            end
            PRLT_ADDR_LED:
            begin
               wword = merge(led_word(q), s.wdata, s.wstrb);
               s.col_route = wword[PRLT_COL_ROUTE_BIT];
               s.pol = wword[PRLT_POL_BIT]; // see (R05)
               s.led_src = wword[PRLT_SRC_LSB +: 4];
               s.alt_route = wword[PRLT_ALT_ROUTE_BIT];
               s.route_en = wword[PRLT_ROUTE_EN_BIT];
            end
            PRLT_ADDR_TEST:
            begin
               // Bits above the field are dropped here, so they read zero
               wword = merge(test_word(q), s.wdata, s.wstrb); // see (R03)
               s.test_cfg = wword[PRLT_TEST_MSB_BIT:0]; // see (R10)
            end
            default:
               wr_ok = 1'b0;
         endcase
         s.bresp = wr_ok ? PRLT_RESP_OKAY : PRLT_RESP_SLVERR;
      end
      s.awready = !s.aw_have && !s.bvalid;
      s.wready = !s.w_have && !s.bvalid;

      if (q.rvalid && s_axi_rready)
         s.rvalid = 1'b0;
      if (q.arready && s_axi_arvalid)
      begin
         s.rvalid = 1'b1;
         s.rdata = {16'h0000, rword};
         s.rresp = rd_ok ? PRLT_RESP_OKAY : PRLT_RESP_SLVERR;
      end
      s.arready = !s.rvalid;

      // Restart clears circuitry state such as the stretch timer
      if (q.restart || q.phy_reset)
         s.stretch = '0;
      else if (activity)
         s.stretch = STRETCH_LOAD;
      else if (q.stretch != '0)
         s.stretch = PRLT_STRETCH_W'(q.stretch - 1'b1);

      s.col_pin = q.col_route ? led_drive : collision_in; // see (R04) (R16)
      s.alt_pin = (q.route_en && q.alt_route) ? led_drive
         : alt_pin_func_in; // see (R07) (R08) (R16)
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         q <= REG_RST;
      else
         q <= s;
   end

   // Generator restarts on either reset kind and on any change of the
   // selection, so it needs no clearing between two non-zero values
   prlt_test_gen u_gen
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .restart(q.restart | q.phy_reset), // see (R14)
      .test_cfg(q.test_cfg),
      .tx_bit(gen_bit),
      .active(gen_active),
      .mode_10t(gen_10t)
   );

   assign s_axi_awready = q.awready;
   assign s_axi_wready = q.wready;
   assign s_axi_bresp = q.bresp;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_arready = q.arready;
   assign s_axi_rdata = q.rdata;
   assign s_axi_rresp = q.rresp;
   assign s_axi_rvalid = q.rvalid;
   assign col_pin_out = q.col_pin;
   assign alt_pin_out = q.alt_pin;
   assign phy_reset_pulse = q.phy_reset;
   assign restart_pulse = q.restart;
   assign test_tx_bit = gen_bit;
   assign test_active = gen_active;
   assign test_mode_10t = gen_10t;

endmodule

// ---- hw/prlt_test_gen.sv ----
// Compliance test pattern generator for 10Base-T and 100Base-TX
`timescale 1ns/1ns
module prlt_test_gen
   import prlt_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic restart,
   input wire logic [5:0] test_cfg,
   output logic tx_bit,
   output logic active,
   output logic mode_10t
);

   typedef struct packed
   {
      logic [4:0] cnt;
      logic [7:0] lfsr;
      logic first;
      logic [5:0] cfg_last;
      logic tx_bit;
      logic active;
      logic mode_10t;
   } prlt_gen_t;

   localparam prlt_gen_t GEN_RST = '{lfsr: PRLT_LFSR_SEED, first: 1'b1,
      default: '0};

   prlt_gen_t q;
   prlt_gen_t s;
   logic [4:0] zeros;
   logic [1:0] idle;
   logic is_10t;

   always_comb
   begin
      s = q;
      is_10t = test_cfg[PRLT_TEST_10T_BIT];
      zeros = {test_cfg[PRLT_TEST_MSB_BIT], test_cfg[3:0]};
      idle = 2'(test_cfg[3:0] - PRLT_PAT_IDLE_00);
      s.lfsr = {q.lfsr[6:0], q.lfsr[7] ^ q.lfsr[5] ^ q.lfsr[4] ^ q.lfsr[3]};
      // Any change of selection starts the pattern from its first bit
      if (restart || test_cfg != q.cfg_last)
      begin
         s.cnt = '0;
         s.first = 1'b1;
         s.cfg_last = test_cfg;
         // Reseeded so every restart replays the same random stream
         s.lfsr = GEN_RST.lfsr;
      end
      else
      begin
         s.first = 1'b0;
         if (!is_10t && q.cnt == zeros)
            s.cnt = '0; // see (R12)
         else
            s.cnt = 5'(q.cnt + 5'h01);
      end
      s.mode_10t = is_10t; // see (R10)
      if (is_10t)
      begin
         s.active = 1'b1;
         unique case (test_cfg[3:0]) // see (R11)
            PRLT_PAT_LINK_PULSE, PRLT_PAT_PULSE_1, PRLT_PAT_ONE_IDLE:
               s.tx_bit = q.first;
            PRLT_PAT_PULSE_0, PRLT_PAT_ZERO_IDLE:
               s.tx_bit = 1'b0;
            PRLT_PAT_REP_1:
               s.tx_bit = 1'b1;
            PRLT_PAT_REP_0:
               s.tx_bit = 1'b0;
            PRLT_PAT_PREAMBLE:
               s.tx_bit = ~q.cnt[0];
            PRLT_PAT_1001:
               s.tx_bit = q.cnt[1] ~^ q.cnt[0];
            PRLT_PAT_RANDOM:
               s.tx_bit = q.lfsr[0];
            PRLT_PAT_IDLE_00, PRLT_PAT_IDLE_01, PRLT_PAT_IDLE_10,
            PRLT_PAT_IDLE_11:
               s.tx_bit = idle[q.cnt[0]];
            default:
               s.tx_bit = 1'b0;
         endcase
      end
      else
      begin
         // A single one, then the selected number of zeros
         s.active = zeros != PRLT_TEST_OFF; // see (R13)
         // Low while the counter restarts, else the first one is doubled
         s.tx_bit = s.active && q.cnt == '0 && !s.first; // see (R12)
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         q <= GEN_RST;
      else
         q <= s;
   end

   assign tx_bit = q.tx_bit;
   assign active = q.active;
   assign mode_10t = q.mode_10t;

endmodule

// ---- inc/prlt_pkg.sv ----
// Constants and types shared by the PHY reset, LED and test register bank
package prlt_pkg;

   // Register indices as printed; byte address is four times the index
   localparam logic [5:0] PRLT_IDX_RESET = 6'h1F;
   localparam logic [5:0] PRLT_IDX_LED = 6'h25;
   localparam logic [5:0] PRLT_IDX_TEST = 6'h27;
   localparam int PRLT_ADDR_W = 8;
   localparam logic [7:0] PRLT_ADDR_RESET = {PRLT_IDX_RESET, 2'h0};
   localparam logic [7:0] PRLT_ADDR_LED = {PRLT_IDX_LED, 2'h0};
   localparam logic [7:0] PRLT_ADDR_TEST = {PRLT_IDX_TEST, 2'h0};

   // Reset control fields
   localparam int PRLT_SOFT_RESET_BIT = 15;
   localparam int PRLT_RESTART_BIT = 14;

   // LED control fields
   localparam int PRLT_COL_ROUTE_BIT = 10;
   localparam int PRLT_POL_BIT = 9;
   localparam int PRLT_SRC_LSB = 3;
   localparam int PRLT_ALT_ROUTE_BIT = 1;
   localparam int PRLT_ROUTE_EN_BIT = 0;

   // Compliance test fields
   localparam int PRLT_TEST_MSB_BIT = 5;
   localparam int PRLT_TEST_10T_BIT = 4;
   localparam logic [4:0] PRLT_TEST_OFF = 5'h00;

   // AXI responses
   localparam logic [1:0] PRLT_RESP_OKAY = 2'h0;
   localparam logic [1:0] PRLT_RESP_SLVERR = 2'h2;

   // LED source selection
   typedef enum logic [3:0]
   {
      PRLT_SRC_LINK = 4'h0,
      PRLT_SRC_ACT = 4'h1,
      PRLT_SRC_TX_ACT = 4'h2,
      PRLT_SRC_RX_ACT = 4'h3,
      PRLT_SRC_COL = 4'h4,
      PRLT_SRC_SPEED_100 = 4'h5,
      PRLT_SRC_SPEED_10 = 4'h6,
      PRLT_SRC_FULL_DUPLEX = 4'h7,
      PRLT_SRC_LINK_BLINK = 4'h8,
      PRLT_SRC_STRETCH = 4'h9,
      PRLT_SRC_LINK_100FD = 4'hA
   } prlt_led_src_t;

   // 10Base-T pattern selection
   typedef enum logic [3:0]
   {
      PRLT_PAT_LINK_PULSE = 4'h0,
      PRLT_PAT_PULSE_1 = 4'h1,
      PRLT_PAT_PULSE_0 = 4'h2,
      PRLT_PAT_REP_1 = 4'h3,
      PRLT_PAT_REP_0 = 4'h4,
      PRLT_PAT_PREAMBLE = 4'h5,
      PRLT_PAT_ONE_IDLE = 4'h6,
      PRLT_PAT_ZERO_IDLE = 4'h7,
      PRLT_PAT_1001 = 4'h8,
      PRLT_PAT_RANDOM = 4'h9,
      PRLT_PAT_IDLE_00 = 4'hA,
      PRLT_PAT_IDLE_01 = 4'hB,
      PRLT_PAT_IDLE_10 = 4'hC,
      PRLT_PAT_IDLE_11 = 4'hD
   } prlt_pattern_t;

   localparam logic [7:0] PRLT_LFSR_SEED = 8'hA5;

   // Activity stretch time
   localparam int PRLT_CLK_PERIOD_NS = 10;
   localparam int PRLT_STRETCH_MS = 50;
   localparam int PRLT_STRETCH_CYCLES =
      PRLT_STRETCH_MS * 1000000 / PRLT_CLK_PERIOD_NS;
   localparam int PRLT_STRETCH_W = 23;

endpackage

// ---- verif/prlt_axil_master.sv ----
// Management-side AXI4-Lite master model for the register bank
`timescale 1ns/1ns
module prlt_axil_master
(
   input wire logic aclk,
   output logic [7:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   output logic [7:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   initial
   begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
      {s_axi_arvalid, s_axi_rready} = '0;
   end
   // Released payloads are inverted so stale values never look valid
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0000, d};
      s_axi_wstrb <= 4'h3;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready)
         begin
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr <= ~a;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            s_axi_wvalid <= 1'b0;
            s_axi_wdata <= ~s_axi_wdata;
         end
      end
      while (!(s_axi_bvalid && s_axi_bready));
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_arvalid <= 1'b0;
            s_axi_araddr <= ~a;
         end
      end
      while (!(s_axi_rvalid && s_axi_rready));
      s_axi_rready <= 1'b0;
   endtask
endmodule

// ---- verif/prlt_regs_chk.sv ----
// Concurrent checks on the register bank ports
`timescale 1ns/1ns
module prlt_regs_chk
   import prlt_pkg::*;
#(
   parameter int STRETCH_CYCLES = 8
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic phy_reset_pulse,
   input wire logic restart_pulse,
   input wire logic test_active
);
   logic mapped;
   logic ar_take;
   assign mapped = s_axi_araddr == PRLT_ADDR_RESET ||
      s_axi_araddr == PRLT_ADDR_LED || s_axi_araddr == PRLT_ADDR_TEST;
   assign ar_take = s_axi_arvalid && s_axi_arready;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_bresp_hold:
   assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_rdata_hold:
   assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read data dropped early");
   a_no_ready_bvalid:
   assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   a_ar_blocked:
   assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while data pending");
   a_unmapped_read:
   assert property (ar_take && !mapped |=> s_axi_rvalid &&
      s_axi_rresp == PRLT_RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   a_mapped_read:
   assert property (ar_take && mapped |=> s_axi_rvalid &&
      s_axi_rresp == PRLT_RESP_OKAY && s_axi_rdata[31:16] == 16'h0)
      else $error("mapped read wrong");
   a_reset_reads_zero:
   assert property (ar_take && s_axi_araddr == PRLT_ADDR_RESET |=>
      s_axi_rdata == 32'h0)
      else $error("reset control reads nonzero");
   a_soft_pulse_one:
   assert property (phy_reset_pulse |=> !phy_reset_pulse)
      else $error("soft reset pulse too long");
   a_restart_one:
   assert property ($rose(restart_pulse) |=> !restart_pulse)
      else $error("restart pulse too long");
   a_soft_clears_test:
   assert property (phy_reset_pulse |-> ##[1:4] !test_active)
      else $error("test mode survives soft reset");
endmodule
bind prlt_regs prlt_regs_chk #(.STRETCH_CYCLES(STRETCH_CYCLES)) u_chk (.*);

// ---- verif/prlt_regs_tb_top.sv ----
// Self-checking testbench for the register bank
`timescale 1ns/1ns
module prlt_regs_tb_top
   import prlt_pkg::*;
;
   logic aclk, aresetn;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic link_ok, rx_activity, tx_activity, collision_in, speed_100;
   logic full_duplex, alt_pin_func_in, col_pin_strap, led_function_strap;
   logic col_pin_out, alt_pin_out, phy_reset_pulse, restart_pulse;
   logic test_tx_bit, test_active, test_mode_10t;
   logic [33:0] wq[$], rq[$];
   logic [4:0] nz [3] = '{5'h01, 5'h11, 5'h1F};
   logic [15:0] v;
   logic b;
   int fails = 0, n_checks = 0, n_soft = 0, n_rst = 0;
   prlt_regs #(.STRETCH_CYCLES(8)) dut (.*);
   prlt_axil_master m (.*);
   task automatic check(input string what, input logic [33:0] seen,
      input logic [33:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic wreg(input logic [7:0] a, input logic [15:0] d,
      input logic [1:0] r);
      wq.push_back({32'h0, r});
      m.wr(a, d);
   endtask
   task automatic rreg(input logic [7:0] a, input logic [15:0] d,
      input logic [1:0] r);
      rq.push_back({r, 16'h0, d});
      m.rd(a);
   endtask
   // Sources in select order; inputs are held long enough to outlast stretch
   task automatic pins(input logic [15:0] c);
      logic [10:0] s;
      logic led;
      s = {link_ok & speed_100 & full_duplex, rx_activity | tx_activity,
         link_ok & ~(rx_activity | tx_activity), full_duplex, ~speed_100,
         speed_100, collision_in, rx_activity, tx_activity,
         rx_activity | tx_activity, link_ok};
      led = s[c[6:3]] ^ c[9];
      check("col_pin", col_pin_out, c[10] ? led : collision_in);
      check("alt_pin", alt_pin_out, c[1] & c[0] ? led : alt_pin_func_in);
   endtask
   task automatic zeros(input int n);
      int k;
      k = 0;
      while (test_tx_bit !== 1'b1 && k < 40)
      begin
         @(negedge aclk);
         k++;
      end
      for (int j = 0; j < n; j++)
      begin
         @(negedge aclk);
         check("tx_zero", test_tx_bit, 1'b0);
      end
      @(negedge aclk);
      check("tx_one", test_tx_bit, 1'b1);
   endtask
   always @(posedge aclk)
   begin
      if (s_axi_bvalid && s_axi_bready)
         check("bresp", {32'h0, s_axi_bresp}, wq.pop_front());
      if (s_axi_rvalid && s_axi_rready)
         check("rdata", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
      if (phy_reset_pulse === 1'b1)
         n_soft++;
      if (restart_pulse === 1'b1)
         n_rst++;
   end
   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   initial
   begin
      repeat (20000) @(posedge aclk);
      fails++;
      stop_test();
   end
   initial
   begin
      {aresetn, link_ok, rx_activity, tx_activity, collision_in} = '0;
      {speed_100, full_duplex, alt_pin_func_in, led_function_strap} = '0;
      col_pin_strap = 1'b1;
      void'($urandom(32'hFF74));
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rreg(PRLT_ADDR_LED, 16'h0200, PRLT_RESP_OKAY);
      rreg(PRLT_ADDR_TEST, 16'h0000, PRLT_RESP_OKAY);
      wreg(PRLT_ADDR_LED, 16'hFFFF, PRLT_RESP_OKAY);
      rreg(PRLT_ADDR_LED, 16'h067B, PRLT_RESP_OKAY);
      wreg(PRLT_ADDR_TEST, 16'hFFFF, PRLT_RESP_OKAY);
      rreg(PRLT_ADDR_TEST, 16'h003F, PRLT_RESP_OKAY);
      wreg(PRLT_ADDR_RESET, 16'h3FFF, PRLT_RESP_OKAY);
      rreg(PRLT_ADDR_RESET, 16'h0000, PRLT_RESP_OKAY);
      wreg(8'h80, 16'h1234, PRLT_RESP_SLVERR);
      rreg(8'h80, 16'h0000, PRLT_RESP_SLVERR);
      rreg(8'h95, 16'h0000, PRLT_RESP_SLVERR);
      check("pulses", 34'(n_soft + n_rst), 34'h0);
      for (int i = 0; i < 22; i++)
      begin
         v = 16'($urandom);
         v[6:3] = 4'(i % 11);
         wreg(PRLT_ADDR_LED, v, PRLT_RESP_OKAY);
         rreg(PRLT_ADDR_LED, v & 16'h067B, PRLT_RESP_OKAY);
         {link_ok, rx_activity, tx_activity, collision_in, speed_100,
            full_duplex, alt_pin_func_in} <= 7'($urandom);
         repeat (16) @(posedge aclk);
         @(negedge aclk);
         pins(v);
      end
      // Speed is forced in a register held outside this block
      wreg(8'h00, 16'h0000, PRLT_RESP_SLVERR);
      foreach (nz[i])
      begin
         wreg(PRLT_ADDR_TEST, 16'h0000, PRLT_RESP_OKAY);
         wreg(PRLT_ADDR_TEST, {10'h0, nz[i][4], 1'b0, nz[i][3:0]},
            PRLT_RESP_OKAY);
         repeat (3) @(negedge aclk);
         check("active", test_active, 1'b1);
         check("mode_10t", test_mode_10t, 1'b0);
         zeros(int'(nz[i]));
      end
      wreg(PRLT_ADDR_TEST, 16'h0000, PRLT_RESP_OKAY);
      repeat (3) @(negedge aclk);
      check("test_off", test_active, 1'b0);
      for (int p = 0; p < 14; p++)
      begin
         wreg(PRLT_ADDR_TEST, 16'h0000, PRLT_RESP_OKAY);
         wreg(PRLT_ADDR_TEST, 16'(16 + p), PRLT_RESP_OKAY);
         repeat (3) @(negedge aclk);
         check("mode_10t", {test_mode_10t, test_active}, 2'h3);
         b = test_tx_bit;
         // Preamble alternates every bit; the repetitive patterns never do
         if (p >= 3 && p <= 5)
            repeat (4)
            begin
               @(negedge aclk);
               check("rep_bit", test_tx_bit, p == 5 ? !b : p == 3);
               b = test_tx_bit;
            end
      end
      wreg(PRLT_ADDR_LED, 16'h0431, PRLT_RESP_OKAY);
      wreg(PRLT_ADDR_RESET, 16'h4000, PRLT_RESP_OKAY);
      repeat (4) @(posedge aclk);
      check("restart", {n_rst[15:0], n_soft[15:0]}, 34'h10000);
      rreg(PRLT_ADDR_LED, 16'h0431, PRLT_RESP_OKAY);
      rreg(PRLT_ADDR_TEST, 16'h001D, PRLT_RESP_OKAY);
      // New straps must be picked up by the soft reset
      col_pin_strap <= 1'b0;
      led_function_strap <= 1'b1;
      wreg(PRLT_ADDR_RESET, 16'h8000, PRLT_RESP_OKAY);
      repeat (4) @(negedge aclk);
      check("soft", {n_rst[15:0], n_soft[15:0]}, 34'h10001);
      check("soft_test", test_active, 1'b0);
      rreg(PRLT_ADDR_LED, 16'h0040, PRLT_RESP_OKAY);
      rreg(PRLT_ADDR_TEST, 16'h0000, PRLT_RESP_OKAY);
      rreg(PRLT_ADDR_RESET, 16'h0000, PRLT_RESP_OKAY);
      repeat (2) @(posedge aclk);
      stop_test();
   end
endmodule
